// >>> pwm_consts.svh
`ifndef PWM_CONSTS_SVH
`define PWM_CONSTS_SVH

// bank shape
`define NUM_CH_DEF 6
`define DIV_W_DEF 16

// register byte offsets
`define A_CTRL 8'h00
`define A_STATUS 8'h04
`define A_INVERT 8'h08
// channel n occupies 16 bytes at 16*n, n = 1..NUM_CH
`define F_CFG 4'h0
`define F_DIV 4'h4
`define F_TRIG 4'h8

// field positions
`define B_ENABLE 0
`define B_SINGLE 1
`define B_CLKSEL 2
`define B_GROUP 3
`define B_JOINT 0
`define B_FIRE 0
`define B_APPLY 1
`define B_LVL 8
`define DIV_HI_LSB 0
`define DIV_LO_LSB 16

// reset values
`define RST_WORD 32'h0000_0000
`define RST_CFG 36'h0_0000_0000

`endif

// >>> pwm_pkg.sv
`include "pwm_consts.svh"

package pwm_pkg;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_HIGH,
        ST_LOW
    } chan_state_t;

    typedef struct packed {
        logic [`DIV_W_DEF-1:0] low_div;
        logic [`DIV_W_DEF-1:0] high_div;
        logic group;
        logic clk_sel;
        logic single;
        logic enable;
    } chan_cfg_t;

endpackage

// >>> pwm_channel.sv
`timescale 1ns/1ps
`include "pwm_consts.svh"

module pwm_channel (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // control
    input wire logic tick,
    input pwm_pkg::chan_cfg_t cfg,
    input wire logic load,
    input wire logic fire,
    // state
    output logic level,
    output logic busy
);

    pwm_pkg::chan_state_t state, next_state;
    logic [`DIV_W_DEF-1:0] cnt, next_cnt;

    always_comb begin
        next_state = state;
        next_cnt = cnt;
        if (!cfg.enable || load) begin
            next_state = pwm_pkg::ST_IDLE;
        end else begin
            unique case (state)
                pwm_pkg::ST_IDLE: begin
                    if (!cfg.single || fire) begin
                        next_state = pwm_pkg::ST_HIGH;
                        next_cnt = cfg.high_div;
                    end
                end
                pwm_pkg::ST_HIGH: begin
                    if (tick) begin
                        if (cnt == '0) begin
                            next_state = cfg.single ? pwm_pkg::ST_IDLE : pwm_pkg::ST_LOW;
                            next_cnt = cfg.low_div;
                        end else begin
                            next_cnt = cnt - 1'b1;
                        end
                    end
                end
                pwm_pkg::ST_LOW: begin
                    if (tick) begin
                        if (cnt == '0) begin
                            next_state = pwm_pkg::ST_HIGH;
                            next_cnt = cfg.high_div;
                        end else begin
                            next_cnt = cnt - 1'b1;
                        end
                    end
                end
                default: next_state = pwm_pkg::ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= pwm_pkg::ST_IDLE;
            cnt <= '0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
        end
    end

    assign level = (state == pwm_pkg::ST_HIGH);
    assign busy = (state != pwm_pkg::ST_IDLE);

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence last_high_tick;
        state == pwm_pkg::ST_HIGH && tick && cnt == '0 && cfg.enable && !load;
    endsequence

    off_goes_idle_a: assert property (!cfg.enable |=> state == pwm_pkg::ST_IDLE)
        else $error("disabled channel left idle");
    high_count_a: assert property (state == pwm_pkg::ST_HIGH && tick && cnt != '0
        && cfg.enable && !load |=> state == pwm_pkg::ST_HIGH && cnt == $past(cnt) - 1'b1)
        else $error("high phase did not count down");
    single_ends_a: assert property (last_high_tick and cfg.single |=> state == pwm_pkg::ST_IDLE)
        else $error("single pulse did not end");
    cont_to_low_a: assert property (last_high_tick and !cfg.single
        |=> state == pwm_pkg::ST_LOW && cnt == $past(cfg.low_div))
        else $error("continuous mode missed low phase");
    hold_no_tick_a: assert property (busy && !tick && cfg.enable && !load |=> $stable(cnt))
        else $error("count moved without a tick");

endmodule

// >>> pwm_bank.sv
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "pwm_consts.svh"

// Summary of operation
// - up to six independent channels
// - square wave with programmed duty cycle
// - timing counted from selected input clock
// - separate 16-bit high and low divides
// - apply individually or jointly together
// - invert one output of a pair
// - continuous or single pulse mode
// - clock select: fast PLL or crystal
module pwm_bank #(
    parameter int NUM_CH = `NUM_CH_DEF
) (
    // apb slave
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    // channel source clocks, sampled as plain inputs
    input wire logic pll_clk_in,
    input wire logic xtal_clk_in,
    // outputs to loads
    output logic [NUM_CH-1:0] pwm_out
);

    localparam int NUM_PAIR = NUM_CH / 2;

    // source clock synchronisers and rising-edge ticks
    logic pll_s1, pll_s2, pll_s3;
    logic xtal_s1, xtal_s2, xtal_s3;
    logic pll_tick, xtal_tick;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pll_s1 <= 1'b0;
            pll_s2 <= 1'b0;
            pll_s3 <= 1'b0;
            xtal_s1 <= 1'b0;
            xtal_s2 <= 1'b0;
            xtal_s3 <= 1'b0;
        end else begin
            pll_s1 <= pll_clk_in;
            pll_s2 <= pll_s1;
            pll_s3 <= pll_s2;
            xtal_s1 <= xtal_clk_in;
            xtal_s2 <= xtal_s1;
            xtal_s3 <= xtal_s2;
        end
    end

    // the pll source must stay below pclk/2 or edges are lost
    assign pll_tick = pll_s2 & ~pll_s3;
    assign xtal_tick = xtal_s2 & ~xtal_s3;

    // register state
    pwm_pkg::chan_cfg_t cfg_pend [NUM_CH];
    pwm_pkg::chan_cfg_t next_cfg_pend [NUM_CH];
    pwm_pkg::chan_cfg_t cfg_act [NUM_CH];
    pwm_pkg::chan_cfg_t next_cfg_act [NUM_CH];
    logic [NUM_CH-1:0] apply_req, next_apply_req;
    logic [NUM_CH-1:0] fire, next_fire;
    logic joint, next_joint;
    logic [NUM_PAIR-1:0] invert, next_invert;
    logic next_pready, next_pslverr;
    logic [31:0] next_prdata;
    logic [NUM_CH-1:0] next_pwm_out;
    logic [NUM_CH-1:0] level, busy, tick_sel, load;

    // address decode
    logic access, commit, ch_hit;
    logic [3:0] ch_num;
    logic [3:0] field;
    int ch_idx;

    assign access = psel & penable;
    assign commit = access & pready;
    assign ch_num = paddr[7:4];
    assign field = paddr[3:0];
    assign ch_hit = (ch_num != 4'h0) && (32'(ch_num) <= NUM_CH)
        && (field == `F_CFG || field == `F_DIV || field == `F_TRIG);
    assign ch_idx = ch_hit ? int'(ch_num) - 1 : 0;

    // read mux and write effects
    always_comb begin
        next_pready = access & ~pready;
        next_pslverr = pslverr;
        next_prdata = prdata;
        next_invert = invert;
        next_joint = 1'b0;
        next_apply_req = '0;
        next_fire = '0;
        for (int i = 0; i < NUM_CH; i++) begin
            next_cfg_pend[i] = cfg_pend[i];
        end
        if (access && !pready) begin
            next_pslverr = 1'b0;
            next_prdata = `RST_WORD;
            if (paddr == `A_CTRL) begin
                next_prdata = `RST_WORD;
            end else if (paddr == `A_STATUS) begin
                next_prdata[NUM_CH-1:0] = busy;
                next_prdata[`B_LVL +: NUM_CH] = pwm_out;
            end else if (paddr == `A_INVERT) begin
                next_prdata[NUM_PAIR-1:0] = invert;
            end else if (ch_hit) begin
                if (field == `F_CFG) begin
                    next_prdata[`B_ENABLE] = cfg_pend[ch_idx].enable;
                    next_prdata[`B_SINGLE] = cfg_pend[ch_idx].single;
                    next_prdata[`B_CLKSEL] = cfg_pend[ch_idx].clk_sel;
                    next_prdata[`B_GROUP] = cfg_pend[ch_idx].group;
                end else if (field == `F_DIV) begin
                    next_prdata[`DIV_HI_LSB +: `DIV_W_DEF] = cfg_pend[ch_idx].high_div;
                    next_prdata[`DIV_LO_LSB +: `DIV_W_DEF] = cfg_pend[ch_idx].low_div;
                end
            end else begin
                next_pslverr = 1'b1;
            end
        end
        if (commit && pwrite && !pslverr) begin
            if (paddr == `A_CTRL) begin
                next_joint = pwdata[`B_JOINT];
            end else if (paddr == `A_INVERT) begin
                next_invert = pwdata[NUM_PAIR-1:0];
            end else if (ch_hit) begin
                if (field == `F_CFG) begin
                    next_cfg_pend[ch_idx].enable = pwdata[`B_ENABLE];
                    next_cfg_pend[ch_idx].single = pwdata[`B_SINGLE];
                    next_cfg_pend[ch_idx].clk_sel = pwdata[`B_CLKSEL];
                    next_cfg_pend[ch_idx].group = pwdata[`B_GROUP];
                    // an ungrouped channel takes its settings at once
                    next_apply_req[ch_idx] = ~pwdata[`B_GROUP];
                end else if (field == `F_DIV) begin
                    next_cfg_pend[ch_idx].high_div = pwdata[`DIV_HI_LSB +: `DIV_W_DEF];
                    next_cfg_pend[ch_idx].low_div = pwdata[`DIV_LO_LSB +: `DIV_W_DEF];
                    next_apply_req[ch_idx] = ~cfg_pend[ch_idx].group;
                end else begin
                    next_fire[ch_idx] = pwdata[`B_FIRE];
                    next_apply_req[ch_idx] = pwdata[`B_APPLY];
                end
            end
        end
    end

    // pending to active transfer; a joint strobe moves every grouped channel together
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            load[i] = apply_req[i] | (joint & cfg_pend[i].group);
            next_cfg_act[i] = load[i] ? cfg_pend[i] : cfg_act[i];
            tick_sel[i] = cfg_act[i].clk_sel ? xtal_tick : pll_tick;
        end
    end

    // differential pairs invert the odd member
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_pwm_out[i] = level[i];
            if (i % 2 == 1 && i / 2 < NUM_PAIR) begin
                next_pwm_out[i] = level[i] ^ invert[i / 2];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `RST_WORD;
            invert <= '0;
            joint <= 1'b0;
            apply_req <= '0;
            fire <= '0;
            pwm_out <= '0;
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_pend[i] <= `RST_CFG;
                cfg_act[i] <= `RST_CFG;
            end
        end else begin
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
            invert <= next_invert;
            joint <= next_joint;
            apply_req <= next_apply_req;
            fire <= next_fire;
            pwm_out <= next_pwm_out;
            for (int i = 0; i < NUM_CH; i++) begin
                cfg_pend[i] <= next_cfg_pend[i];
                cfg_act[i] <= next_cfg_act[i];
            end
        end
    end

    // one independent engine per channel
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        pwm_channel u_ch (
            .pclk(pclk),
            .presetn(presetn),
            .tick(tick_sel[g]),
            .cfg(cfg_act[g]),
            .load(load[g]),
            .fire(fire[g]),
            .level(level[g]),
            .busy(busy[g])
        );
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence apb_access;
        psel && penable && !pready;
    endsequence

    sequence apb_done;
        pready ##1 !pready;
    endsequence

    apb_answer_a: assert property (apb_access |=> apb_done)
        else $error("apb answer not one cycle after access");
    joint_apply_a: assert property (joint && cfg_pend[2].group
        |=> cfg_act[2] == $past(cfg_pend[2]))
        else $error("joint update missed channel 2");
    held_no_load_a: assert property (!load[0] |=> $stable(cfg_act[0]))
        else $error("active settings changed without apply");
    pair_invert_a: assert property (##1 pwm_out[1] == $past(level[1] ^ invert[0]))
        else $error("pair output not inverted as set");
    plain_out_a: assert property (##1 pwm_out[0] == $past(level[0]))
        else $error("even output not following level");
    // checked against the synchroniser stages, not the tick expression itself
    clk_select_a: assert property (tick_sel[0] == (cfg_act[0].clk_sel
        ? ($past(xtal_s1) && !$past(xtal_s2)) : ($past(pll_s1) && !$past(pll_s2))))
        else $error("wrong source tick");
    off_low_a: assert property (!cfg_act[0].enable ##1 !cfg_act[0].enable
        |=> !pwm_out[0])
        else $error("disabled channel drove high");
    fire_start_a: assert property (fire[1] && cfg_act[1].enable && cfg_act[1].single
        && !busy[1] && !load[1] |=> ##1 pwm_out[1] != $past(invert[0]))
        else $error("single pulse did not start");

endmodule

// >>> pwm_load.sv
`timescale 1ns/1ps

// passive loads: measure phase lengths in pclk cycles, count rising edges
module pwm_load #(
    parameter int N = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // driven outputs
    input wire logic [N-1:0] pwm_in
);
    int hi_len[N];
    int lo_len[N];
    int rises[N];
    int last_rise[N];
    int cnt[N];
    int now;
    logic [N-1:0] prev;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            now <= 0;
            prev <= '0;
            for (int i = 0; i < N; i++) begin
                hi_len[i] <= 0;
                lo_len[i] <= 0;
                rises[i] <= 0;
                last_rise[i] <= 0;
                cnt[i] <= 0;
            end
        end else begin
            now <= now + 1;
            prev <= pwm_in;
            for (int i = 0; i < N; i++) begin
                if (pwm_in[i] !== prev[i]) begin
                    cnt[i] <= 1;
                    if (prev[i] === 1'b1) begin
                        hi_len[i] <= cnt[i];
                    end else begin
                        lo_len[i] <= cnt[i];
                        rises[i] <= rises[i] + 1;
                        last_rise[i] <= now;
                    end
                end else begin
                    cnt[i] <= cnt[i] + 1;
                end
            end
        end
    end
endmodule

// >>> testbench.sv
`timescale 1ns/1ps
`include "pwm_consts.svh"

module testbench;
    typedef struct {
        logic [7:0] a;
        logic [31:0] w;
        logic [31:0] r;
        logic e;
    } row_t;

    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic pll = 0;
    logic xtal = 0;
    logic [5:0] pwm_out;
    int fails = 0;
    int n_checks = 0;
    logic [31:0] q;
    logic e;
    int r0;
    row_t rows[7] = '{
        '{8'h08, 32'h0000_0005, 32'h0000_0005, 1'b0},
        '{8'h64, 32'h1234_5678, 32'h1234_5678, 1'b0},
        '{8'h60, 32'h0000_0004, 32'h0000_0004, 1'b0},
        '{8'h68, 32'h0000_0000, 32'h0000_0000, 1'b0},
        '{8'h0c, 32'h0000_00ff, 32'h0000_0000, 1'b1},
        '{8'h70, 32'h0000_00ff, 32'h0000_0000, 1'b1},
        '{8'h08, 32'h0000_0000, 32'h0000_0000, 1'b0}
    };

    always #10 pclk = ~pclk;
    // source clocks kept well below pclk/2, since the bank samples them
    always #40 pll = ~pll;
    always #100 xtal = ~xtal;

    pwm_bank #(.NUM_CH(6)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .pll_clk_in(pll),
        .xtal_clk_in(xtal), .pwm_out(pwm_out)
    );

    pwm_load #(.N(6)) load (.pclk(pclk), .presetn(presetn), .pwm_in(pwm_out));

    task chk(input bit ok, input string m);
        n_checks++;
        if (!ok) begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) chk(0, "no pready");
    endtask

    task rd(input logic [7:0] a, input logic [31:0] x, input string m);
        apb(1'b0, a, 32'h0000_0000);
        chk(q === x && e === 1'b0, m);
    endtask

    task wait_cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask

    function automatic bit near(input int got, input int want);
        return got >= want - 1 && got <= want + 1;
    endfunction

    task wrap_up;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #200000;
        chk(0, "watchdog expired");
        wrap_up();
    end

    initial begin
        wait_cyc(8);
        chk(pwm_out === 6'h00, "outputs not low in reset");
        presetn <= 1'b1;
        rd(8'h10, 32'h0000_0000, "cfg not cleared");
        rd(8'h14, 32'h0000_0000, "div not cleared");
        rd(`A_STATUS, 32'h0000_0000, "status not idle");
        $display("reset test done");

        foreach (rows[i]) begin
            apb(1'b1, rows[i].a, rows[i].w);
            chk(e === rows[i].e, "write error flag");
            apb(1'b0, rows[i].a, 32'h0000_0000);
            chk(q === rows[i].r && e === rows[i].e, "register row");
        end
        $display("register rows done");

        apb(1'b1, 8'h14, 32'h0003_0001);
        apb(1'b1, 8'h10, 32'h0000_0001);
        wait_cyc(300);
        chk(near(load.hi_len[0], 8), "pll high phase");
        chk(near(load.lo_len[0], 16), "pll low phase");
        apb(1'b1, 8'h10, 32'h0000_0005);
        wait_cyc(400);
        chk(near(load.hi_len[0], 20), "xtal high phase");
        chk(near(load.lo_len[0], 40), "xtal low phase");
        $display("continuous test done");

        apb(1'b1, 8'h24, 32'h0000_0002);
        apb(1'b1, 8'h20, 32'h0000_0003);
        wait_cyc(50);
        r0 = load.rises[1];
        apb(1'b1, 8'h28, 32'h0000_0001);
        wait_cyc(100);
        chk(load.rises[1] == r0 + 1, "single pulse count");
        // the first source tick of a pulse is partial: 2 full ticks plus 1..4 cycles
        chk(load.hi_len[1] > 8 && load.hi_len[1] <= 12, "single pulse width");
        chk(pwm_out[1] === 1'b0, "single pulse not low after");
        apb(1'b1, 8'h28, 32'h0000_0001);
        wait_cyc(100);
        chk(load.rises[1] == r0 + 2, "second pulse count");
        $display("single pulse test done");

        apb(1'b1, 8'h34, 32'h0001_0001);
        apb(1'b1, 8'h44, 32'h0001_0001);
        apb(1'b1, 8'h30, 32'h0000_0009);
        wait_cyc(40);
        apb(1'b1, 8'h40, 32'h0000_0009);
        wait_cyc(100);
        chk(load.rises[2] == 0 && load.rises[3] == 0, "group applied early");
        apb(1'b1, `A_CTRL, 32'h0000_0001);
        wait_cyc(100);
        chk(load.rises[2] > 0, "group did not start");
        chk(load.last_rise[2] == load.last_rise[3], "group not aligned");
        apb(1'b1, 8'h30, 32'h0000_0008);
        wait_cyc(20);
        r0 = load.rises[2];
        wait_cyc(40);
        chk(load.rises[2] > r0, "grouped channel stopped early");
        apb(1'b1, 8'h38, 32'h0000_0002);
        wait_cyc(20);
        r0 = load.rises[2];
        wait_cyc(40);
        chk(load.rises[2] == r0 && pwm_out[2] === 1'b0, "trigger apply ignored");
        $display("joint update test done");

        apb(1'b1, 8'h30, 32'h0000_0000);
        apb(1'b1, 8'h40, 32'h0000_0000);
        apb(1'b1, 8'h54, 32'h0003_0001);
        apb(1'b1, 8'h50, 32'h0000_0001);
        apb(1'b1, 8'h60, 32'h0000_0001);
        apb(1'b1, 8'h64, 32'h0003_0001);
        apb(1'b1, `A_INVERT, 32'h0000_0006);
        r0 = load.rises[5];
        wait_cyc(20);
        chk(pwm_out[3] === 1'b1, "idle inverted output");
        wait_cyc(80);
        chk(load.rises[5] > r0 + 2, "channel six idle");
        chk(load.hi_len[5] == load.lo_len[4], "pair not complementary");
        chk(load.last_rise[4] != 0, "channel five idle");
        apb(1'b0, `A_STATUS, 32'h0000_0000);
        chk(q[7:0] === 8'h31 && e === 1'b0, "status busy bits");
        $display("invert test done");

        @(posedge pclk);
        presetn <= 1'b0;
        wait_cyc(3);
        chk(pwm_out === 6'h00, "outputs not low in second reset");
        presetn <= 1'b1;
        rd(8'h10, 32'h0000_0000, "cfg kept over reset");
        rd(`A_INVERT, 32'h0000_0000, "invert kept over reset");
        $display("second reset test done");
        wrap_up();
    end
endmodule
